//--- rtl/rffvc_top.sv
`timescale 1ns/1ns
module rffvc_top #(
	parameter int ADDR_W                      = 18,
	parameter int DATA_W                      = 32,
	parameter int FIFO_DEPTH                  = 16,
	parameter bit build_enhanced_group_filter = 1'b1,
	parameter bit build_rx_tag_remove         = 1'b1,
	parameter bit build_tx_tag_remove         = 1'b1,
	parameter bit build_rx_tag_insert         = 1'b1,
	parameter bit build_tx_tag_insert         = 1'b1
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// AXI4-Lite register port
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Receive stream from the MAC, frame class given with the first word
	input  wire logic              rx_in_valid,
	output logic                   rx_in_ready,
	input  wire logic [DATA_W-1:0] rx_in_data,
	input  wire logic              rx_in_last,
	input  wire logic              rx_in_broadcast,
	input  wire logic              rx_in_group,
	input  wire logic              rx_in_errored,
	input  wire logic              rx_in_addr_pass,
	// Filtered receive stream
	output logic                   rx_out_valid,
	input  wire logic              rx_out_ready,
	output logic [DATA_W-1:0]      rx_out_data,
	output logic                   rx_out_last,
	// Tag value registers held elsewhere
	input  wire logic [31:0]       rx_inserted_tag_value,
	input  wire logic [31:0]       tx_inserted_tag_value,
	// Effective modes for the datapaths
	output logic [1:0]             rx_tag_remove_mode,
	output logic [1:0]             tx_tag_remove_mode,
	output logic [1:0]             rx_tag_insert_mode,
	output logic [1:0]             tx_tag_insert_mode,
	output logic                   enhanced_group_filter_enable,
	output logic [31:0]            rx_insert_tag,
	output logic [31:0]            tx_insert_tag
);

	initial begin
		if (DATA_W < 1) begin
			$error("data width must be positive");
		end
	end

	logic [31:0]      ctrl;
	logic             newer_q, newer_d;
	logic [1:0]       rxr_q, rxr_d, txr_q, txr_d, rxi_q, rxi_d, txi_q, txi_d;
	logic             enh_q, enh_d;
	logic [31:0]      rx_inserted_tag_value_q, rx_inserted_tag_value_d, tx_inserted_tag_value_q, tx_inserted_tag_value_d;
	logic             in_frame_q, in_frame_d, drop_q, drop_d;
	logic             accept, take, drop_now, fifo_in_ready;
	logic [1:0]       f_rxr, f_txr, f_rxi, f_txi;

	// -----------------------------------------------------------------
	// Register slave
	// -----------------------------------------------------------------
	rffvc_regs #(.ADDR_W(ADDR_W)) u_regs (
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.ctrl          (ctrl)
	);

	// -----------------------------------------------------------------
	// Effective feature modes
	// -----------------------------------------------------------------
	always_comb begin
		f_rxr   = ctrl[rffvc_pkg::RX_REMOVE_LSB +: 2];
		f_txr   = ctrl[rffvc_pkg::TX_REMOVE_LSB +: 2];
		f_rxi   = ctrl[rffvc_pkg::RX_INSERT_LSB +: 2];
		f_txi   = ctrl[rffvc_pkg::TX_INSERT_LSB +: 2];
		newer_d = ctrl[rffvc_pkg::BIT_NEWER];
		// Reserved removal code behaves as no removal.
		if (f_rxr == rffvc_pkg::MODE_TAGGED) begin
			f_rxr = rffvc_pkg::MODE_NONE;
		end
		if (f_txr == rffvc_pkg::MODE_TAGGED) begin
			f_txr = rffvc_pkg::MODE_NONE;
		end
		// A feature not built stays off whatever software sets.
		rxr_d = (newer_d && build_rx_tag_remove) ? f_rxr : rffvc_pkg::MODE_NONE;
		txr_d = (newer_d && build_tx_tag_remove) ? f_txr : rffvc_pkg::MODE_NONE;
		rxi_d = (newer_d && build_rx_tag_insert) ? f_rxi : rffvc_pkg::MODE_NONE;
		txi_d = (newer_d && build_tx_tag_insert) ? f_txi : rffvc_pkg::MODE_NONE;
		enh_d = newer_d && build_enhanced_group_filter
		      && ctrl[rffvc_pkg::BIT_ENH_FILTER];
		// Inserted tags come straight from their value registers.
		rx_inserted_tag_value_d = rx_inserted_tag_value;
		tx_inserted_tag_value_d = tx_inserted_tag_value;
	end

	// Mode registers.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			newer_q <= 1'b0;
			rxr_q   <= rffvc_pkg::MODE_NONE;
			txr_q   <= rffvc_pkg::MODE_NONE;
			rxi_q   <= rffvc_pkg::MODE_NONE;
			txi_q   <= rffvc_pkg::MODE_NONE;
			enh_q   <= 1'b0;
			rx_inserted_tag_value_q  <= 32'h0000_0000;
			tx_inserted_tag_value_q  <= 32'h0000_0000;
		end else begin
			newer_q <= newer_d;
			rxr_q   <= rxr_d;
			txr_q   <= txr_d;
			rxi_q   <= rxi_d;
			txi_q   <= txi_d;
			enh_q   <= enh_d;
			rx_inserted_tag_value_q  <= rx_inserted_tag_value_d;
			tx_inserted_tag_value_q  <= tx_inserted_tag_value_d;
		end
	end

	// -----------------------------------------------------------------
	// Receive frame acceptance
	// -----------------------------------------------------------------
	always_comb begin
		// Broadcast frames bypass address filtering; only their own bit or the errored check drops them.
		if (rx_in_broadcast) begin
			accept = !ctrl[rffvc_pkg::BIT_DROP_BCAST];
		end else if (rx_in_group) begin
			// Group reject overrides mask and table, which keep their contents.
			// A promiscuous mask shows up as a pass here, so groups beyond the table get in.
			accept = !ctrl[rffvc_pkg::BIT_DROP_GROUP] && rx_in_addr_pass;
		end else begin
			accept = rx_in_addr_pass;
		end
		// Errored frames go on as good ones only while allowed.
		if (rx_in_errored && !ctrl[rffvc_pkg::BIT_ACCEPT_BAD]) begin
			accept = 1'b0;
		end
		take       = rx_in_valid && fifo_in_ready;
		drop_now   = in_frame_q ? drop_q : !accept;
		in_frame_d = take ? !rx_in_last : in_frame_q;
		drop_d     = (take && !in_frame_q) ? !accept : drop_q;
	end

	// Frame tracking registers.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			in_frame_q <= 1'b0;
			drop_q     <= 1'b0;
		end else begin
			in_frame_q <= in_frame_d;
			drop_q     <= drop_d;
		end
	end

	// -----------------------------------------------------------------
	// Output buffer for accepted words
	// -----------------------------------------------------------------
	rffvc_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.in_valid  (rx_in_valid && !drop_now),
		.in_ready  (fifo_in_ready),
		.in_data   ({rx_in_last, rx_in_data}),
		.out_valid (rx_out_valid),
		.out_ready (rx_out_ready),
		.out_data  ({rx_out_last, rx_out_data})
	);

	assign rx_in_ready                  = fifo_in_ready;
	assign rx_tag_remove_mode           = rxr_q;
	assign tx_tag_remove_mode           = txr_q;
	assign rx_tag_insert_mode           = rxi_q;
	assign tx_tag_insert_mode           = txi_q;
	assign enhanced_group_filter_enable = enh_q;
	assign rx_insert_tag                = rx_inserted_tag_value_q;
	assign tx_insert_tag                = tx_inserted_tag_value_q;

endmodule : rffvc_top

//--- rtl/rffvc_pkg.sv
// Functional notes
// - Group reject drops frames, table left untouched.
// - Promiscuous mask plus no reject accepts groups.
// - Only broadcast reject or a disallowed error discards broadcast frames.
// - Newer feature bits reset to disabled.
// - Bits 31-15 and 13 read zero.
// - Bit 14 forwards errored frames as good.
// - Bit 12 enables enhanced filter if built.
// - Bit 11 gates all newer features.
// - Newer enable ignores features not built.
// - Bits 10-9 select receive tag removal.
// - Receive removal acts only when built.
// - Bits 8-7 select transmit tag removal.
// - Transmit removal acts only when built.
// - Bits 6-5 select receive tag insertion.
// - Receive inserted tag comes from its register.
// - Receive insertion acts only when built.
// - Bit 2 rejects all broadcast frames.
// - Bit 1 rejects all group frames not flagged broadcast.
// - Bits 4-3 select transmit tag insertion.
package rffvc_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [31:0] CTRL_OFFSET    = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam logic [31:0] CTRL_WR_MASK   = 32'h0000_5ffe;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int BIT_ACCEPT_BAD   = 14;
	localparam int BIT_ENH_FILTER   = 12;
	localparam int BIT_NEWER        = 11;
	localparam int RX_REMOVE_LSB    = 9;
	localparam int TX_REMOVE_LSB    = 7;
	localparam int RX_INSERT_LSB    = 5;
	localparam int TX_INSERT_LSB    = 3;
	localparam int BIT_DROP_BCAST   = 2;
	localparam int BIT_DROP_GROUP   = 1;

	// -----------------------------------------------------------------
	// Mode encodings and bus responses
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_NONE     = 2'h0,
		MODE_ALL      = 2'h1,
		MODE_TAGGED   = 2'h2,
		MODE_SELECTED = 2'h3
	} rffvc_mode_t;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : rffvc_pkg

//--- rtl/rffvc_fifo.sv
`timescale 1ns/1ns
module rffvc_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int PW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
			$error("fifo depth must be a power of two of at least 2");
		end
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wptr_q, wptr_d, rptr_q, rptr_d;
	logic [PW:0]      count_q, count_d;
	logic             in_ready_q, in_ready_d;
	logic             out_valid_q, out_valid_d;
	logic [WIDTH-1:0] out_data_q, out_data_d;
	logic             push, pop;

	// -----------------------------------------------------------------
	// Pointer and output stage next values
	// -----------------------------------------------------------------
	always_comb begin
		push        = in_valid && in_ready_q;
		pop         = (count_q != '0) && (!out_valid_q || out_ready);
		wptr_d      = push ? wptr_q + 1'b1 : wptr_q;
		rptr_d      = pop ? rptr_q + 1'b1 : rptr_q;
		count_d     = count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
		in_ready_d  = count_d < (PW+1)'(DEPTH);
		out_valid_d = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid_q);
		out_data_d  = pop ? mem_q[rptr_q] : out_data_q;
	end

	// Storage is written only; it needs no reset.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wptr_q] <= in_data;
		end
	end

	// Control registers.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wptr_q      <= '0;
			rptr_q      <= '0;
			count_q     <= '0;
			in_ready_q  <= 1'b0;
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end else begin
			wptr_q      <= wptr_d;
			rptr_q      <= rptr_d;
			count_q     <= count_d;
			in_ready_q  <= in_ready_d;
			out_valid_q <= out_valid_d;
			out_data_q  <= out_data_d;
		end
	end

	assign in_ready  = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data  = out_data_q;

endmodule : rffvc_fifo

//--- rtl/rffvc_regs.sv
`timescale 1ns/1ns
module rffvc_regs #(
	parameter int ADDR_W = 18
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Stored control word
	output logic [31:0]            ctrl
);

	initial begin
		if (ADDR_W < 3 || ADDR_W > 32) begin
			$error("address width out of range");
		end
	end

	logic        awready_q, awready_d, bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic        arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d, ctrl_q, ctrl_d, strb_mask;
	logic        wr_go, rd_go, wr_hit, rd_hit;

	// -----------------------------------------------------------------
	// Write and read handshakes, one access in flight per direction
	// -----------------------------------------------------------------
	always_comb begin
		wr_go     = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
		rd_go     = s_axi_arvalid && !arready_q && !rvalid_q;
		wr_hit    = {{(32-ADDR_W){1'b0}}, s_axi_awaddr[ADDR_W-1:2], 2'h0} == rffvc_pkg::CTRL_OFFSET;
		rd_hit    = {{(32-ADDR_W){1'b0}}, s_axi_araddr[ADDR_W-1:2], 2'h0} == rffvc_pkg::CTRL_OFFSET;
		strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
		             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		awready_d = wr_go;
		bvalid_d  = wr_go ? 1'b1 : (s_axi_bready ? 1'b0 : bvalid_q);
		bresp_d   = wr_go ? (wr_hit ? rffvc_pkg::RESP_OKAY : rffvc_pkg::RESP_SLVERR) : bresp_q;
		ctrl_d    = ctrl_q;
		if (wr_go && wr_hit) begin
			// Reserved positions never take a written one.
			ctrl_d = (ctrl_q & ~(strb_mask & rffvc_pkg::CTRL_WR_MASK))
			       | (s_axi_wdata & strb_mask & rffvc_pkg::CTRL_WR_MASK);
		end
		arready_d = rd_go;
		rvalid_d  = rd_go ? 1'b1 : (s_axi_rready ? 1'b0 : rvalid_q);
		rresp_d   = rd_go ? (rd_hit ? rffvc_pkg::RESP_OKAY : rffvc_pkg::RESP_SLVERR) : rresp_q;
		rdata_d   = rd_go ? (rd_hit ? ctrl_q : 32'h0000_0000) : rdata_q;
	end

	// Every field resets to its disabled value.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			awready_q <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= rffvc_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= rffvc_pkg::RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			ctrl_q    <= rffvc_pkg::CTRL_RESET;
		end else begin
			awready_q <= awready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			ctrl_q    <= ctrl_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = awready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign ctrl          = ctrl_q;

endmodule : rffvc_regs

//--- test/rffvc_props.sv
`timescale 1ns/1ns
module rffvc_props #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 32
) (
	// Clock and reset
	input wire logic              mclk,
	input wire logic              sys_rst,
	// Register port
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	// Streams and datapath controls
	input wire logic              rx_in_ready,
	input wire logic              rx_out_valid,
	input wire logic              rx_out_ready,
	input wire logic [DATA_W-1:0] rx_out_data,
	input wire logic [31:0]       rx_inserted_tag_value,
	input wire logic [31:0]       rx_insert_tag,
	input wire logic [1:0]        rx_tag_remove_mode,
	input wire logic [1:0]        tx_tag_remove_mode
);
	// -----------------------------------------------------------------
	// Properties
	// -----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	// Bus answers, holding and refusal of unmapped words.
	write_ack_a: assert property (s_axi_awready |-> s_axi_wready && s_axi_bvalid)
		else $error("write answer incomplete");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	wr_unmapped_a: assert property (s_axi_awready && s_axi_awaddr != '0
		|-> s_axi_bresp == rffvc_pkg::RESP_SLVERR) else $error("unmapped write not refused");
	rd_unmapped_a: assert property (s_axi_arready && s_axi_araddr != '0
		|-> s_axi_rvalid && s_axi_rresp == rffvc_pkg::RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");
	rsv_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == '0 && !s_axi_rdata[13])
		else $error("reserved bits read nonzero");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed while held");
	rxout_hold_a: assert property (rx_out_valid && !rx_out_ready
		|=> rx_out_valid && $stable(rx_out_data)) else $error("output word changed while held");
	tag_copy_a: assert property (!$past(sys_rst)
		|-> rx_insert_tag == $past(rx_inserted_tag_value)) else $error("inserted tag not copied");
	remove_rsv_a: assert property (rx_tag_remove_mode != 2'h2 && tx_tag_remove_mode != 2'h2)
		else $error("reserved removal code passed on");
	reset_clear_a: assert property (disable iff (1'h0) $past(sys_rst) |-> !s_axi_bvalid
		&& !s_axi_rvalid && !rx_in_ready && !rx_out_valid && rx_tag_remove_mode == 2'h0)
		else $error("outputs not cleared by reset");

	// Main scenarios reached.
	cover property (s_axi_bvalid && s_axi_bresp == rffvc_pkg::RESP_SLVERR);
	cover property (rx_out_valid && !rx_out_ready);
	cover property (rx_tag_remove_mode == 2'h3 && !rx_in_ready);
endmodule : rffvc_props

bind rffvc_top rffvc_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_rffvc_props (.mclk, .sys_rst,
	.s_axi_awaddr, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.rx_in_ready, .rx_out_valid, .rx_out_ready, .rx_out_data, .rx_inserted_tag_value,
	.rx_insert_tag, .rx_tag_remove_mode, .tx_tag_remove_mode);

//--- test/rffvc_top_tb.sv
`timescale 1ns/1ns
module rffvc_top_tb;
	// Clock, reset and register port
	logic        mclk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r2;
	// Streams and datapath controls
	logic        rx_in_valid, rx_in_ready, rx_in_last, rx_in_broadcast, rx_in_group;
	logic        rx_in_errored, rx_in_addr_pass, rx_out_valid, rx_out_ready, rx_out_last;
	logic        enhanced_group_filter_enable, out_hold, ok;
	logic [31:0] rx_in_data, rx_out_data, rx_inserted_tag_value, tx_inserted_tag_value;
	logic [31:0] rx_insert_tag, tx_insert_tag, seq;
	logic [1:0]  rx_tag_remove_mode, tx_tag_remove_mode, rx_tag_insert_mode, tx_tag_insert_mode;
	logic [32:0] exp_q[$], got_q[$];
	int          n_errors, checks, cyc, n;

	rffvc_top u_rffvc_top (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in_valid, .rx_in_ready, .rx_in_data,
		.rx_in_last, .rx_in_broadcast, .rx_in_group, .rx_in_errored, .rx_in_addr_pass,
		.rx_out_valid, .rx_out_ready, .rx_out_data, .rx_out_last, .rx_inserted_tag_value,
		.tx_inserted_tag_value, .rx_tag_remove_mode, .tx_tag_remove_mode, .rx_tag_insert_mode,
		.tx_tag_insert_mode, .enhanced_group_filter_enable, .rx_insert_tag, .tx_insert_tag);

	// -----------------------------------------------------------------
	// Clock, output stalls and output capture
	// -----------------------------------------------------------------
	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end

	// The drain side stalls every third cycle, or fully while out_hold is set.
	always @(negedge mclk) begin
		cyc++;
		rx_out_ready = !out_hold && (cyc % 3 != 0);
	end

	// Every word handed over on the drain side is kept for comparison.
	always @(posedge mclk) begin
		if (!sys_rst && rx_out_valid === 1'h1 && rx_out_ready === 1'h1)
			got_q.push_back({rx_out_last, rx_out_data});
	end

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// One register access; the response ready is held low for stall cycles.
	task automatic axi(input logic wr, input logic [17:0] a, input logic [31:0] d,
		input logic [3:0] s, input int stall, output logic [31:0] q, output logic [1:0] r);
		int k;
		k = 0;
		@(negedge mclk);
		s_axi_awaddr = a;
		s_axi_araddr = a;
		s_axi_wdata = d;
		s_axi_wstrb = s;
		s_axi_awvalid = wr;
		s_axi_wvalid = wr;
		s_axi_arvalid = !wr;
		s_axi_bready = wr && stall == 0;
		s_axi_rready = !wr && stall == 0;
		do @(posedge mclk); while ((wr ? s_axi_awready : s_axi_arready) !== 1'h1 && ++k < 20);
		if (stall != 0) begin
			@(negedge mclk);
			{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
			repeat (stall - 1) @(negedge mclk);
			s_axi_bready = wr;
			s_axi_rready = !wr;
			@(posedge mclk);
		end
		chk(33'(wr ? s_axi_bvalid : s_axi_rvalid), 33'h1, "response valid");
		q = s_axi_rdata;
		r = wr ? s_axi_bresp : s_axi_rresp;
		@(negedge mclk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h0;
	endtask : axi

	task automatic wr_chk(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'h1, a, d, s, cyc % 3, q, r);
		chk(33'(r), 33'(er), "write response");
	endtask : wr_chk

	task automatic rd_chk(input logic [17:0] a, input int stall, input logic [31:0] ed,
		input logic [1:0] er);
		logic [31:0] q;
		logic [1:0]  r;
		axi(1'h0, a, 32'h0, 4'h0, stall, q, r);
		chk({r[0], q}, {er[0], ed}, "read data");
		chk(33'(r), 33'(er), "read response");
	endtask : rd_chk

	// The effective modes settle one cycle after the control word is written.
	task automatic modes(input logic [8:0] e);
		@(posedge mclk);
		@(negedge mclk);
		chk(33'({enhanced_group_filter_enable, rx_tag_remove_mode, tx_tag_remove_mode,
			rx_tag_insert_mode, tx_tag_insert_mode}), 33'(e), "modes");
	endtask : modes

	task automatic send(input int nw, input logic [3:0] f, input logic pass);
		int k;
		for (int i = 0; i < nw; i++) begin
			@(negedge mclk);
			{rx_in_broadcast, rx_in_group, rx_in_errored, rx_in_addr_pass} = f;
			rx_in_valid = 1'h1;
			rx_in_data = seq;
			rx_in_last = (i == nw - 1);
			k = 0;
			do @(posedge mclk); while (rx_in_ready !== 1'h1 && ++k < 200);
			if (pass)
				exp_q.push_back({rx_in_last, rx_in_data});
			seq++;
		end
		@(negedge mclk);
		rx_in_valid = 1'h0;
	endtask : send

	task automatic drain(input string t);
		int k;
		k = 0;
		while (got_q.size() < exp_q.size() && k++ < 400) @(negedge mclk);
		repeat (10) @(negedge mclk);
		chk(33'(got_q.size()), 33'(exp_q.size()), "word count");
		foreach (exp_q[i])
			if (i < got_q.size())
				chk(got_q[i], exp_q[i], "word");
		exp_q.delete();
		got_q.delete();
		$display("test %s done", t);
	endtask : drain

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// -----------------------------------------------------------------
	// Watchdog and test sequence
	// -----------------------------------------------------------------
	initial begin
		#3_000_000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{rx_in_valid, rx_in_last, rx_in_broadcast, rx_in_group} = 4'h0;
		{rx_in_errored, rx_in_addr_pass, rx_in_data, seq, out_hold} = '0;
		rx_inserted_tag_value = 32'h0;
		tx_inserted_tag_value = 32'h0;
		sys_rst = 1'h1;
		repeat (8) @(negedge mclk);
		sys_rst = 1'h0;
		rd_chk(18'h0, 2, 32'h0, rffvc_pkg::RESP_OKAY);
		modes(9'h0);
		wr_chk(18'h0, 32'hffff_ffff, 4'hf, rffvc_pkg::RESP_OKAY);
		rd_chk(18'h0, 0, 32'h0000_5ffe, rffvc_pkg::RESP_OKAY);
		wr_chk(18'h0, 32'h0, 4'h1, rffvc_pkg::RESP_OKAY);
		rd_chk(18'h0, 1, 32'h0000_5f00, rffvc_pkg::RESP_OKAY);
		wr_chk(18'h4, 32'hffff_ffff, 4'hf, rffvc_pkg::RESP_SLVERR);
		wr_chk(18'h3_fffc, 32'h0, 4'hf, rffvc_pkg::RESP_SLVERR);
		rd_chk(18'h4, 1, 32'h0, rffvc_pkg::RESP_SLVERR);
		rd_chk(18'h0, 0, 32'h0000_5f00, rffvc_pkg::RESP_OKAY);
		$display("test register access done");
		for (int k = 0; k < 3; k++) begin
			for (int m = 0; m < 4; m++) begin
				v = (k == 2 ? 32'h1000 : (k == 0 ? 32'h1800 : 32'h0800));
				v = v | (32'(m) << 9) | (32'(m) << 7) | (32'(m) << 5) | (32'(m) << 3);
				r2 = (m == 2) ? 2'h0 : 2'(m);
				wr_chk(18'h0, v, 4'hf, rffvc_pkg::RESP_OKAY);
				modes(k == 2 ? 9'h0 : {k == 0, r2, r2, 2'(m), 2'(m)});
				rd_chk(18'h0, m, v, rffvc_pkg::RESP_OKAY);
			end
		end
		$display("test mode selection done");
		for (int t = 0; t < 2; t++) begin
			rx_inserted_tag_value = 32'h8100_0abc ^ {32{t[0]}};
			tx_inserted_tag_value = ~rx_inserted_tag_value;
			repeat (2) @(negedge mclk);
			chk(33'(rx_insert_tag), 33'(rx_inserted_tag_value), "inserted tag");
			chk(33'(tx_insert_tag), 33'(tx_inserted_tag_value), "tx tag");
		end
		$display("test tag value done");
		for (int c = 0; c < 8; c++) begin
			wr_chk(18'h0, (32'(c[2]) << 14) | (32'(c[1]) << 2) | (32'(c[0]) << 1), 4'hf,
				rffvc_pkg::RESP_OKAY);
			repeat (2) @(negedge mclk);
			for (int f = 0; f < 16; f++) begin
				ok = !(f[3] && c[1]) && !(f[2] && !f[3] && (c[0] || !f[0])) && (f[3] || f[0]);
				ok = ok && !(f[1] && !c[2]);
				send(1 + f % 3, f[3:0], ok);
			end
			drain("frame filter");
		end
		// Fill the buffer with the drain side stopped, then let it empty.
		out_hold = 1'h1;
		n = 0;
		{rx_in_broadcast, rx_in_group, rx_in_errored, rx_in_addr_pass} = 4'h1;
		repeat (40) begin
			@(negedge mclk);
			{rx_in_valid, rx_in_last, rx_in_data} = {2'h3, seq};
			@(posedge mclk);
			if (rx_in_ready === 1'h1) begin
				exp_q.push_back({1'h1, seq});
				seq++;
				n++;
			end
		end
		chk(33'(n >= 16 && n < 40), 33'h1, "buffer refused");
		out_hold = 1'h0;
		while (rx_in_ready !== 1'h1) @(posedge mclk);
		exp_q.push_back({1'h1, seq});
		@(negedge mclk);
		rx_in_valid = 1'h0;
		drain("buffer fill");
		sys_rst = 1'h1;
		repeat (2) @(negedge mclk);
		sys_rst = 1'h0;
		rd_chk(18'h0, 0, 32'h0, rffvc_pkg::RESP_OKAY);
		$display("test second reset done");
		report_and_stop();
	end
endmodule : rffvc_top_tb
